// File: tb/flash_erase_pd_assertions.sv
`default_nettype none
// ----------------------------------------
// erase and power-down checks
// ----------------------------------------
module flash_erase_pd_assertions #(
	parameter int BLOCK_ERASE_CYCLES = 2000,
	parameter int CHIP_ERASE_CYCLES  = 4000
) (
	input wire logic                          sys_clk,
	input wire logic                          srst,
	input wire logic                          cs_n,
	input wire logic                          so_oe_n,
	input wire logic                          write_in_progress,
	input wire logic                          write_enable_latch,
	input wire logic                          in_power_down,
	input wire logic                          erase_start,
	input wire spi_flash_pkg::erase_kind_type erase_kind,
	input wire logic [23:0]                   erase_addr,
	input wire logic [4:0]                    block_protect_bits,
	input wire logic                          protect_complement
);
	timeunit 1ns;
	timeprecision 1ps;
	import spi_flash_pkg::*;

	localparam int BLK_MAX = BLOCK_ERASE_CYCLES + 8;
	localparam int CHP_MAX = CHIP_ERASE_CYCLES + 8;

	// ----------------------------------------
	// deselected time counter
	// ----------------------------------------
	logic [15:0] hi_cnt_ff;
	logic [15:0] nxt_hi_cnt;

	always_comb
	begin
		nxt_hi_cnt = hi_cnt_ff;
		if (!cs_n)
			nxt_hi_cnt = 16'h0;
		else if (hi_cnt_ff != 16'hffff)
			nxt_hi_cnt = hi_cnt_ff + 16'h1;
	end

	always_ff @(posedge sys_clk)
		hi_cnt_ff <= srst ? 16'h0 : nxt_hi_cnt;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_blk_start;
		erase_start && erase_kind != ERASE_CHIP;
	endsequence
	sequence s_chp_start;
		erase_start && erase_kind == ERASE_CHIP;
	endsequence
	sequence s_blk_done;
		write_in_progress[*8] ##[1:BLK_MAX] !write_in_progress;
	endsequence
	sequence s_chp_done;
		write_in_progress[*8] ##[1:CHP_MAX] !write_in_progress;
	endsequence

	a_erase_needs_latch: assert property (
		erase_start |-> $past(write_enable_latch))
		else $error("erase started with latch clear");
	a_start_sets_busy: assert property (
		erase_start |-> write_in_progress && !write_enable_latch)
		else $error("erase start without busy or with latch");
	a_start_deselected: assert property (
		erase_start |-> cs_n && $past(cs_n))
		else $error("erase started while selected");
	a_block_busy_time: assert property (
		s_blk_start |-> s_blk_done)
		else $error("block erase busy time wrong");
	a_chip_busy_time: assert property (
		s_chp_start |-> s_chp_done)
		else $error("chip erase busy time wrong");
	a_chip_prot_ok: assert property (
		s_chp_start |-> (block_protect_bits[2:0] == 3'd0
		&& !protect_complement) || (block_protect_bits[2:0] == 3'd7
		&& protect_complement))
		else $error("chip erase under protection");
	a_base_aligned: assert property (
		erase_start |-> (erase_kind == ERASE_32K && erase_addr[14:0] == 0)
		|| (erase_kind == ERASE_64K && erase_addr[15:0] == 0)
		|| (erase_kind == ERASE_CHIP && erase_addr == 0))
		else $error("erase base address misaligned");
	a_busy_no_sleep: assert property (
		write_in_progress |-> !in_power_down)
		else $error("power-down during erase");
	a_sleep_no_erase: assert property (
		in_power_down |-> !erase_start)
		else $error("erase while powered down");
	a_sleep_entry_delay: assert property (
		$rose(in_power_down) |-> hi_cnt_ff >= POWER_DOWN_ENTRY_CYCLES)
		else $error("power-down entered too early");
	a_busy_quiet_out: assert property (
		write_in_progress |-> so_oe_n)
		else $error("output driven during erase");
	a_out_release: assert property (
		$rose(cs_n) |-> ##[1:6] so_oe_n)
		else $error("output not released after deselect");
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spi_flash_pkg::*;

	localparam int unsigned BLK_CYC = 300;
	localparam int unsigned CHP_CYC = 950;
	localparam logic [7:0]  ID_VAL  = 8'h3c; // arbitrary value

	logic           sys_clk;
	logic           srst;
	logic           cmd_valid;
	logic [7:0]     cmd_opcode;
	logic [23:0]    cmd_addr;
	logic [1:0]     cmd_addr_bytes;
	logic [7:0]     cmd_read_bytes;
	logic           cmd_ready;
	logic [7:0]     rd_data;
	logic           rd_valid;
	logic           cmd_done;
	logic [4:0]     block_protect_bits;
	logic           protect_complement;
	logic           write_in_progress;
	logic           write_enable_latch;
	logic           in_power_down;
	logic           erase_start;
	erase_kind_type erase_kind;
	logic [23:0]    erase_addr;
	int             failures = 0;
	int             tests_run = 0;
	int             starts = 0;
	int             reads = 0;

	spi_link_if link ();

	flash_erase_pd_dev #(.BLOCK_ERASE_CYCLES(BLK_CYC),
		.CHIP_ERASE_CYCLES(CHP_CYC), .DEVICE_ID(ID_VAL))
	flash_erase_pd_dev_inst (.sys_clk(sys_clk), .srst(srst), .link(link),
		.block_protect_bits(block_protect_bits),
		.protect_complement(protect_complement),
		.write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch),
		.in_power_down(in_power_down), .erase_start(erase_start),
		.erase_kind(erase_kind), .erase_addr(erase_addr));

	flash_erase_pd_host flash_erase_pd_host_inst (.sys_clk(sys_clk),
		.srst(srst), .link(link), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
		.cmd_addr_bytes(cmd_addr_bytes), .cmd_read_bytes(cmd_read_bytes),
		.cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.cmd_done(cmd_done));

	flash_erase_pd_assertions #(.BLOCK_ERASE_CYCLES(BLK_CYC),
		.CHIP_ERASE_CYCLES(CHP_CYC))
	flash_erase_pd_assertions_inst (.sys_clk(sys_clk), .srst(srst),
		.cs_n(link.cs_n), .so_oe_n(link.so_oe_n),
		.write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch),
		.in_power_down(in_power_down), .erase_start(erase_start),
		.erase_kind(erase_kind), .erase_addr(erase_addr),
		.block_protect_bits(block_protect_bits),
		.protect_complement(protect_complement));

	// ----------------------------------------
	// clock, erase counter, shared tasks
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		if (erase_start === 1'b1)
			starts <= starts + 1;

	always @(posedge sys_clk)
		if (rd_valid === 1'b1)
			reads <= reads + 1;

	task automatic check(input bit ok, input string msg);
		tests_run++;
		if (!ok)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic run_cmd(input logic [7:0] op, input logic [23:0] ad,
		input logic [1:0] ab, input logic [7:0] rb);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(posedge sys_clk);
			n++;
		end
		cmd_opcode <= op;
		cmd_addr <= ad;
		cmd_addr_bytes <= ab;
		cmd_read_bytes <= rb;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		n = 0;
		while (cmd_done !== 1'b1 && n < 20000)
		begin
			@(posedge sys_clk);
			n++;
		end
		check(n < 20000, "command never completed");
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (write_in_progress === 1'b1 && n < 3000)
		begin
			@(posedge sys_clk);
			n++;
		end
		check(n < 3000, "erase cycle too long");
	endtask

	task automatic try_erase(input logic [7:0] op, input logic [23:0] ad,
		input logic [1:0] ab, input logic [4:0] bp, input logic cp,
		input int exp, input erase_kind_type k, input logic [23:0] base);
		int s;
		block_protect_bits <= bp;
		protect_complement <= cp;
		s = starts;
		run_cmd(op, ad, ab, 8'h00);
		repeat (8) @(posedge sys_clk);
		check(starts == s + exp, "erase start count");
		if (exp != 0)
		begin
			check(erase_kind === k, "erase kind");
			check(erase_addr === base, "erase base address");
			check(write_enable_latch === 1'b0, "latch left set");
		end
		wait_idle();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_erase();
		try_erase(OP_ERASE_32K, 24'h019abc, 2'd3, 5'h00, 1'b0, 1,
			ERASE_32K, 24'h018000);
		try_erase(OP_ERASE_64K, 24'h123456, 2'd3, 5'h00, 1'b0, 1,
			ERASE_64K, 24'h120000);
		try_erase(OP_ERASE_64K, 24'h123456, 2'd2, 5'h00, 1'b0, 0,
			ERASE_64K, 24'h0);
		try_erase(OP_ERASE_64K, 24'h7f1234, 2'd3, 5'h01, 1'b0, 0,
			ERASE_64K, 24'h0);
		try_erase(OP_ERASE_32K, 24'h001234, 2'd3, 5'h01, 1'b0, 1,
			ERASE_32K, 24'h0);
		$display("test erase finished");
	endtask

	task automatic t_chip();
		try_erase(OP_CHIP_ERASE_A, 24'h0, 2'd0, 5'h00, 1'b0, 1,
			ERASE_CHIP, 24'h0);
		try_erase(OP_CHIP_ERASE_B, 24'h0, 2'd0, 5'h07, 1'b1, 1,
			ERASE_CHIP, 24'h0);
		try_erase(OP_CHIP_ERASE_A, 24'h0, 2'd0, 5'h01, 1'b0, 0,
			ERASE_CHIP, 24'h0);
		try_erase(OP_CHIP_ERASE_B, 24'h0, 2'd0, 5'h00, 1'b1, 0,
			ERASE_CHIP, 24'h0);
		try_erase(OP_CHIP_ERASE_B, 24'h0, 2'd1, 5'h00, 1'b0, 0,
			ERASE_CHIP, 24'h0);
		$display("test chip finished");
	endtask

	task automatic t_power();
		run_cmd(OP_POWER_DOWN, 24'h0, 2'd0, 8'h00);
		check(in_power_down === 1'b0, "power-down too early");
		repeat (POWER_DOWN_ENTRY_CYCLES + 10) @(posedge sys_clk);
		check(in_power_down === 1'b1, "power-down not entered");
		try_erase(OP_ERASE_64K, 24'h010000, 2'd3, 5'h00, 1'b0, 0,
			ERASE_64K, 24'h0);
		check(in_power_down === 1'b1, "power-down left");
		run_cmd(OP_RELEASE_ID, 24'h0, 2'd0, 8'h00);
		repeat (RELEASE_CYCLES + 10) @(posedge sys_clk);
		check(in_power_down === 1'b0, "release failed");
		try_erase(OP_ERASE_64K, 24'h010000, 2'd3, 5'h00, 1'b0, 1,
			ERASE_64K, 24'h010000);
		$display("test power finished");
	endtask

	task automatic t_id();
		int r;
		r = reads;
		run_cmd(OP_RELEASE_ID, 24'h0, 2'd3, 8'h02);
		check(rd_data === ID_VAL, "id in standby");
		check(reads == r + 2, "id byte count");
		run_cmd(OP_POWER_DOWN, 24'h0, 2'd0, 8'h00);
		repeat (POWER_DOWN_ENTRY_CYCLES + 10) @(posedge sys_clk);
		run_cmd(OP_RELEASE_ID, 24'h0, 2'd3, 8'h01);
		check(rd_data === ID_VAL, "id in power-down");
		repeat (RELEASE_ID_CYCLES + 10) @(posedge sys_clk);
		check(in_power_down === 1'b0, "id release failed");
		$display("test id finished");
	endtask

	task automatic t_busy();
		block_protect_bits <= 5'h00;
		protect_complement <= 1'b0;
		run_cmd(OP_CHIP_ERASE_B, 24'h0, 2'd0, 8'h00);
		run_cmd(OP_POWER_DOWN, 24'h0, 2'd0, 8'h00);
		check(write_in_progress === 1'b1, "erase cut short");
		run_cmd(OP_RELEASE_ID, 24'h0, 2'd0, 8'h00);
		check(write_in_progress === 1'b1, "erase cut by release");
		wait_idle();
		repeat (POWER_DOWN_ENTRY_CYCLES + 10) @(posedge sys_clk);
		check(in_power_down === 1'b0, "power-down during erase");
		$display("test busy finished");
	endtask

	task automatic wrap_up();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		wrap_up();
	end

	initial
	begin
		srst = 1'b1;
		cmd_valid = 1'b0;
		cmd_opcode = 8'h00;
		cmd_addr = 24'h0;
		cmd_addr_bytes = 2'd0;
		cmd_read_bytes = 8'h00;
		block_protect_bits = 5'h00;
		protect_complement = 1'b0;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		t_erase();
		t_chip();
		t_power();
		t_id();
		t_busy();
		wrap_up();
	end
endmodule
`default_nettype wire

// File: verilog/flash_erase_pd_dev.sv
`default_nettype none
// How it works
// - 52h plus three address bytes erases 32 KB
// - d8h plus three address bytes erases 64 KB
// - erase needs write enable latch already set
// - block erase only if exactly 32 bits
// - host keeps select low across whole command
// - select rise starts timed cycle, busy flag
// - latch cleared before erase cycle ends
// - protected block erase is ignored
// - chip erase only if exactly 8 bits
// - chip erase needs all-zero or all-one protection
// - powered down: only release command acts
// - power-down only if exactly 8 bits
// - power-down entered after entry delay
// - power-down rejected while cycle runs
// - idle deselect gives standby, reset gives standby
// - plain release waits release delay, no commands
// - release plus dummies streams id msb first
// - id-form release waits longer release delay
// - release ignored while busy
module flash_erase_pd_dev #(
	parameter int unsigned BLOCK_ERASE_CYCLES = 2000,
	parameter int unsigned CHIP_ERASE_CYCLES  = 4000,
	parameter logic [7:0]  DEVICE_ID          = 8'h5a // arbitrary value
) (
	input  wire logic                        sys_clk,
	input  wire logic                        srst,
	spi_link_if.device                       link,
	input  wire logic [4:0]                  block_protect_bits,
	input  wire logic                        protect_complement,
	output logic                             write_in_progress,
	output logic                             write_enable_latch,
	output logic                             in_power_down,
	output logic                             erase_start,
	output spi_flash_pkg::erase_kind_type    erase_kind,
	output logic [23:0]                      erase_addr
);
	import spi_flash_pkg::*;

	typedef enum {
		ST_STANDBY,
		ST_ERASE,
		ST_DP_ENTRY,
		ST_POWERED_DOWN,
		ST_RELEASE
	} dev_state_type;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic [2:0] prev_ff;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			meta_ff <= 3'h1;
			sync_ff <= 3'h1;
			prev_ff <= 3'h1;
		end
		else
		begin
			meta_ff <= {link.si, link.sclk, link.cs_n};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	logic cs_high;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	assign cs_high   = sync_ff[0];
	assign cs_rise   = sync_ff[0] & ~prev_ff[0];
	assign sclk_rise = sync_ff[1] & ~prev_ff[1] & ~sync_ff[0];
	assign sclk_fall = ~sync_ff[1] & prev_ff[1] & ~sync_ff[0];

	// ----------------------------------------------------------------
	// serial shifter and id output
	// ----------------------------------------------------------------
	logic [5:0]    bit_cnt_ff;
	logic [5:0]    nxt_bit_cnt;
	logic [31:0]   shift_ff;
	logic [31:0]   nxt_shift;
	logic          long_ff;
	logic          nxt_long;
	logic          so_ff;
	logic          nxt_so;
	logic          so_oe_n_ff;
	logic          nxt_so_oe_n;
	dev_state_type state_ff;
	logic          id_allowed;

	assign id_allowed = (shift_ff[31:24] == OP_RELEASE_ID)
		&& ((state_ff == ST_STANDBY) || (state_ff == ST_POWERED_DOWN));

	always_comb
	begin
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift   = shift_ff;
		nxt_long    = long_ff;
		nxt_so      = so_ff;
		nxt_so_oe_n = so_oe_n_ff;
		if (cs_high)
		begin
			nxt_bit_cnt = 6'd0;
			nxt_long    = 1'b0;
			nxt_so_oe_n = 1'b1;
		end
		else
		begin
			if (sclk_rise)
			begin
				if (bit_cnt_ff < BITS_FRAME)
					nxt_shift = {shift_ff[30:0], sync_ff[2]};
				if (bit_cnt_ff >= BITS_FRAME)
					nxt_long = 1'b1;
				if (bit_cnt_ff == BITS_ID_END)
					nxt_bit_cnt = BITS_FRAME;
				else
					nxt_bit_cnt = bit_cnt_ff + 6'd1;
			end
			if (sclk_fall && id_allowed && (bit_cnt_ff >= BITS_FRAME))
			begin
				nxt_so      = DEVICE_ID[3'd7 - bit_cnt_ff[2:0]];
				nxt_so_oe_n = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			bit_cnt_ff <= 6'd0;
			shift_ff   <= 32'h0;
			long_ff    <= 1'b0;
			so_ff      <= 1'b0;
			so_oe_n_ff <= 1'b1;
		end
		else
		begin
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff   <= nxt_shift;
			long_ff    <= nxt_long;
			so_ff      <= nxt_so;
			so_oe_n_ff <= nxt_so_oe_n;
		end
	end

	assign link.so      = so_ff;
	assign link.so_oe_n = so_oe_n_ff;

	// ----------------------------------------------------------------
	// command decode and timed cycles
	// ----------------------------------------------------------------
	dev_state_type        nxt_state;
	logic [TIMER_W-1:0]   timer_ff;
	logic [TIMER_W-1:0]   nxt_timer;
	logic                 wel_ff;
	logic                 nxt_wel;
	logic                 start_ff;
	logic                 nxt_start;
	erase_kind_type       kind_ff;
	erase_kind_type       nxt_kind;
	logic [23:0]          addr_ff;
	logic [23:0]          nxt_addr;
	logic                 wip_ff;
	logic                 pd_ff;
	logic                 len8;
	logic                 len32;
	logic [7:0]           op8;
	logic [7:0]           op32;

	assign len8  = cs_rise && (bit_cnt_ff == BITS_OPCODE) && !long_ff;
	assign len32 = cs_rise && (bit_cnt_ff == BITS_FRAME) && !long_ff;
	assign op8   = shift_ff[7:0];
	assign op32  = shift_ff[31:24];

	always_comb
	begin
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		nxt_wel   = wel_ff;
		nxt_start = 1'b0;
		nxt_kind  = kind_ff;
		nxt_addr  = addr_ff;
		if (timer_ff != '0)
			nxt_timer = timer_ff - 1'b1;
		case (state_ff)
			ST_STANDBY:
			begin
				if (len8 && (op8 == OP_WRITE_ENABLE))
					nxt_wel = 1'b1;
				if (len8 && wel_ff
					&& ((op8 == OP_CHIP_ERASE_A) || (op8 == OP_CHIP_ERASE_B))
					&& chip_erase_ok(block_protect_bits,
						protect_complement))
				begin
					nxt_state = ST_ERASE;
					nxt_timer = TIMER_W'(CHIP_ERASE_CYCLES);
					nxt_wel   = 1'b0;
					nxt_start = 1'b1;
					nxt_kind  = ERASE_CHIP;
					nxt_addr  = 24'h0;
				end
				if (len32 && wel_ff
					&& ((op32 == OP_ERASE_32K) || (op32 == OP_ERASE_64K))
					&& !block_protected(shift_ff[23:0], block_protect_bits,
						protect_complement))
				begin
					nxt_state = ST_ERASE;
					nxt_timer = TIMER_W'(BLOCK_ERASE_CYCLES);
					nxt_wel   = 1'b0;
					nxt_start = 1'b1;
					if (op32 == OP_ERASE_32K)
					begin
						nxt_kind = ERASE_32K;
						nxt_addr = {shift_ff[23:15], 15'h0};
					end
					else
					begin
						nxt_kind = ERASE_64K;
						nxt_addr = {shift_ff[23:16], 16'h0};
					end
				end
				if (len8 && (op8 == OP_POWER_DOWN))
				begin
					nxt_state = ST_DP_ENTRY;
					nxt_timer = TIMER_W'(POWER_DOWN_ENTRY_CYCLES);
				end
			end
			ST_ERASE:
			begin
				// power-down and release frames fall through unused
				if (timer_ff <= TIMER_W'(1))
					nxt_state = ST_STANDBY;
			end
			ST_DP_ENTRY:
			begin
				if (timer_ff <= TIMER_W'(1))
					nxt_state = ST_POWERED_DOWN;
			end
			ST_POWERED_DOWN:
			begin
				if (len8 && (op8 == OP_RELEASE_ID))
				begin
					nxt_state = ST_RELEASE;
					nxt_timer = TIMER_W'(RELEASE_CYCLES);
				end
				if (cs_rise && (bit_cnt_ff == BITS_FRAME || long_ff)
					&& (op32 == OP_RELEASE_ID))
				begin
					nxt_state = ST_RELEASE;
					nxt_timer = TIMER_W'(RELEASE_ID_CYCLES);
				end
			end
			ST_RELEASE:
			begin
				if (timer_ff <= TIMER_W'(1))
					nxt_state = ST_STANDBY;
			end
			default:
			begin
				nxt_state = ST_STANDBY;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_ff <= ST_STANDBY;
			timer_ff <= '0;
			wel_ff   <= 1'b0;
			start_ff <= 1'b0;
			kind_ff  <= ERASE_NONE;
			addr_ff  <= 24'h0;
			wip_ff   <= 1'b0;
			pd_ff    <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			wel_ff   <= nxt_wel;
			start_ff <= nxt_start;
			kind_ff  <= nxt_kind;
			addr_ff  <= nxt_addr;
			wip_ff   <= (nxt_state == ST_ERASE);
			pd_ff    <= (nxt_state == ST_POWERED_DOWN);
		end
	end

	assign write_in_progress  = wip_ff;
	assign write_enable_latch = wel_ff;
	assign in_power_down      = pd_ff;
	assign erase_start        = start_ff;
	assign erase_kind         = kind_ff;
	assign erase_addr         = addr_ff;
endmodule
`default_nettype wire

// File: verilog/flash_erase_pd_host.sv
`default_nettype none
module flash_erase_pd_host #(
	parameter int unsigned HALF_PERIOD = 6
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	spi_link_if.host         link,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_opcode,
	input  wire logic [23:0] cmd_addr,
	input  wire logic [1:0]  cmd_addr_bytes,
	input  wire logic [7:0]  cmd_read_bytes,
	output logic             cmd_ready,
	output logic [7:0]       rd_data,
	output logic             rd_valid,
	output logic             cmd_done
);
	import spi_flash_pkg::*;

	typedef enum {
		H_IDLE,
		H_SETUP,
		H_CLK_HI,
		H_CLK_LO,
		H_GAP
	} host_state_type;

	// ----------------------------------------------------------------
	// serial output synchroniser
	// ----------------------------------------------------------------
	logic so_meta_ff;
	logic so_sync_ff;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			so_meta_ff <= 1'b0;
			so_sync_ff <= 1'b0;
		end
		else
		begin
			so_meta_ff <= link.so;
			so_sync_ff <= so_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	host_state_type     state_ff, nxt_state;
	logic [TIMER_W-1:0] div_ff, nxt_div;
	logic [31:0]        sh_ff, nxt_sh;
	logic [11:0]        idx_ff, nxt_idx;
	logic [11:0]        total_ff, nxt_total;
	logic [11:0]        tx_ff, nxt_tx;
	logic [11:0]        etot_ff, nxt_etot;
	logic               pend_ff, nxt_pend;
	logic [31:0]        hold_ff, nxt_hold;
	logic [7:0]         rsh_ff, nxt_rsh;
	logic               cs_n_ff, nxt_cs_n;
	logic               sclk_ff, nxt_sclk;
	logic               ready_ff, nxt_ready;
	logic               rv_ff, nxt_rv;
	logic               done_ff, nxt_done;
	logic               is_erase;

	assign is_erase = (cmd_opcode == OP_ERASE_32K)
		|| (cmd_opcode == OP_ERASE_64K)
		|| (cmd_opcode == OP_CHIP_ERASE_A)
		|| (cmd_opcode == OP_CHIP_ERASE_B);

	function automatic logic [11:0] frame_bits(
		input logic [1:0] ab,
		input logic [7:0] rb
	);
		return {6'h0, 3'd1 + {1'b0, ab}, 3'h0} + {1'b0, rb, 3'h0};
	endfunction

	always_comb
	begin
		nxt_state = state_ff;
		nxt_div   = div_ff;
		nxt_sh    = sh_ff;
		nxt_idx   = idx_ff;
		nxt_total = total_ff;
		nxt_tx    = tx_ff;
		nxt_etot  = etot_ff;
		nxt_pend  = pend_ff;
		nxt_hold  = hold_ff;
		nxt_rsh   = rsh_ff;
		nxt_cs_n  = cs_n_ff;
		nxt_sclk  = sclk_ff;
		nxt_ready = 1'b0;
		nxt_rv    = 1'b0;
		nxt_done  = 1'b0;
		if (div_ff != '0)
			nxt_div = div_ff - 1'b1;
		case (state_ff)
			H_IDLE:
			begin
				nxt_ready = 1'b1;
				if (cmd_valid && ready_ff)
				begin
					nxt_ready = 1'b0;
					nxt_hold  = {cmd_opcode, cmd_addr};
					nxt_state = H_SETUP;
					nxt_cs_n  = 1'b0;
					nxt_div   = TIMER_W'(HALF_PERIOD);
					nxt_idx   = 12'h0;
					nxt_etot  = frame_bits(cmd_addr_bytes, 8'd0);
					if (is_erase && (cmd_addr_bytes != 2'd0
						|| cmd_opcode != OP_WRITE_ENABLE))
					begin
						// write enable frame goes out first
						nxt_pend  = 1'b1;
						nxt_sh    = {OP_WRITE_ENABLE, 24'h0};
						nxt_total = 12'd8;
						nxt_tx    = 12'd8;
					end
					else
					begin
						nxt_sh    = {cmd_opcode, cmd_addr};
						nxt_total = frame_bits(cmd_addr_bytes, cmd_read_bytes);
						nxt_tx    = frame_bits(cmd_addr_bytes, 8'd0);
					end
				end
			end
			H_SETUP:
			begin
				if (div_ff == '0)
				begin
					nxt_state = H_CLK_HI;
					nxt_sclk  = 1'b1;
					nxt_div   = TIMER_W'(HALF_PERIOD);
				end
			end
			H_CLK_HI:
			begin
				if (div_ff == '0)
				begin
					nxt_state = H_CLK_LO;
					nxt_sclk  = 1'b0;
					nxt_div   = TIMER_W'(HALF_PERIOD);
					nxt_sh    = {sh_ff[30:0], 1'b0};
					nxt_idx   = idx_ff + 12'd1;
					if (idx_ff >= tx_ff)
					begin
						nxt_rsh = {rsh_ff[6:0], so_sync_ff};
						nxt_rv  = (idx_ff[2:0] == 3'd7);
					end
				end
			end
			H_CLK_LO:
			begin
				if (div_ff == '0)
				begin
					nxt_div = TIMER_W'(HALF_PERIOD);
					if (idx_ff == total_ff)
					begin
						nxt_cs_n  = 1'b1;
						nxt_state = H_GAP;
						if (sh_ff[31:24] == 8'h0 && tx_ff == 12'd8
							&& hold_ff[31:24] == OP_RELEASE_ID && !pend_ff)
							nxt_div = TIMER_W'(RELEASE_CYCLES);
						else if (hold_ff[31:24] == OP_RELEASE_ID && !pend_ff)
							nxt_div = TIMER_W'(RELEASE_ID_CYCLES);
					end
					else
					begin
						nxt_state = H_CLK_HI;
						nxt_sclk  = 1'b1;
					end
				end
			end
			H_GAP:
			begin
				if (div_ff == '0)
				begin
					if (pend_ff)
					begin
						nxt_pend  = 1'b0;
						nxt_sh    = hold_ff;
						nxt_total = etot_ff;
						nxt_tx    = etot_ff;
						nxt_idx   = 12'h0;
						nxt_cs_n  = 1'b0;
						nxt_div   = TIMER_W'(HALF_PERIOD);
						nxt_state = H_SETUP;
					end
					else
					begin
						nxt_done  = 1'b1;
						nxt_state = H_IDLE;
					end
				end
			end
			default:
			begin
				nxt_state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_ff <= H_IDLE;
			div_ff   <= '0;
			sh_ff    <= 32'h0;
			idx_ff   <= 12'h0;
			total_ff <= 12'h0;
			tx_ff    <= 12'h0;
			etot_ff  <= 12'h0;
			pend_ff  <= 1'b0;
			hold_ff  <= 32'h0;
			rsh_ff   <= 8'h0;
			cs_n_ff  <= 1'b1;
			sclk_ff  <= 1'b0;
			ready_ff <= 1'b0;
			rv_ff    <= 1'b0;
			done_ff  <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			div_ff   <= nxt_div;
			sh_ff    <= nxt_sh;
			idx_ff   <= nxt_idx;
			total_ff <= nxt_total;
			tx_ff    <= nxt_tx;
			etot_ff  <= nxt_etot;
			pend_ff  <= nxt_pend;
			hold_ff  <= nxt_hold;
			rsh_ff   <= nxt_rsh;
			cs_n_ff  <= nxt_cs_n;
			sclk_ff  <= nxt_sclk;
			ready_ff <= nxt_ready;
			rv_ff    <= nxt_rv;
			done_ff  <= nxt_done;
		end
	end

	assign link.cs_n = cs_n_ff;
	assign link.sclk = sclk_ff;
	assign link.si   = sh_ff[31];
	assign cmd_ready = ready_ff;
	assign rd_data   = rsh_ff;
	assign rd_valid  = rv_ff;
	assign cmd_done  = done_ff;
endmodule
`default_nettype wire

// File: verilog/spi_flash_pkg.sv
`default_nettype none
package spi_flash_pkg;
	// clock
	localparam int unsigned CLK_PERIOD_NS = 10;

	// opcodes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_ERASE_32K    = 8'h52;
	localparam logic [7:0] OP_ERASE_64K    = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_POWER_DOWN   = 8'hb9;
	localparam logic [7:0] OP_RELEASE_ID   = 8'hab;

	// frame lengths in serial bits
	localparam logic [5:0] BITS_OPCODE = 6'd8;
	localparam logic [5:0] BITS_FRAME  = 6'd32;
	localparam logic [5:0] BITS_ID_END = 6'd39;

	// delays in ns and their cycle counts
	localparam int unsigned POWER_DOWN_ENTRY_DELAY_NS = 3000;
	localparam int unsigned RELEASE_DELAY_NS          = 3000;
	localparam int unsigned RELEASE_ID_DELAY_NS       = 5000;
	localparam int unsigned POWER_DOWN_ENTRY_CYCLES =
		(POWER_DOWN_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RELEASE_CYCLES =
		(RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RELEASE_ID_CYCLES =
		(RELEASE_ID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// timer width and reset values
	localparam int unsigned TIMER_W = 24;
	localparam logic [7:0]  DEVICE_ID_RESET = 8'h5a; // arbitrary value

	typedef enum logic [1:0] {
		ERASE_NONE,
		ERASE_32K,
		ERASE_64K,
		ERASE_CHIP
	} erase_kind_type;

	// protected range of 64 KB blocks, top or bottom, complement inverts
	function automatic logic block_protected(
		input logic [23:0] addr,
		input logic [4:0]  bp,
		input logic        cmp
	);
		logic [7:0] span;
		logic [7:0] idx;
		logic       hit;
		span = (bp[2:0] == 3'd0) ? 8'd0 : (8'd1 << (bp[2:0] - 3'd1));
		idx  = {1'b0, addr[22:16]};
		hit  = bp[3] ? (idx < span) : (idx >= (8'd128 - span));
		return hit ^ cmp;
	endfunction

	function automatic logic chip_erase_ok(
		input logic [4:0] bp,
		input logic       cmp
	);
		return ((bp[2:0] == 3'd0) && !cmp) || ((bp[2:0] == 3'd7) && cmp);
	endfunction
endpackage
`default_nettype wire

// File: verilog/spi_link_if.sv
`default_nettype none
interface spi_link_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe_n;

	modport device (
		input  cs_n,
		input  sclk,
		input  si,
		output so,
		output so_oe_n
	);

	modport host (
		output cs_n,
		output sclk,
		output si,
		input  so,
		input  so_oe_n
	);
endinterface
`default_nettype wire
